// ### core/micro_support_control_bits.sv
// processor-support control and status bits of the supply controller
// assumes a serial bus engine on clk giving one-cycle rd/wr strobes;
// raw pins arrive asynchronously and are synchronised here
// Functional notes
// [R1] a latched flag clears on read unless its fault is still present then.
// [R2] software keeps re-reading latched flags until they read clear.
// [R3] the power-on request pin state reads at bit 6 of register 02h.
// [R4] bit 1 of register 12h drives internal power-on; zero turns it off.
// [R5] the power-on request pin can be sampled without reaching the debounce logic.
// [R6] software debounces the mirrored request and writes it to every controller.
// [R7] any fault asserts the alert output to call the processor.
// [R8] the line-sense input state reads at bit 7 of register 02h.
// [R9] bit 5 of register 12h drives the internal line-sense function.
// [R10] line-sense pass-through is configurable while sensing keeps working.
// [R11] bit 2 of register 13h releases the share clamp over the ramp release.
// [R12] bit 1 of register 13h drives the fault output pin directly.
// [R13] bit 0 of register 13h clears the fault output latch.
// [R14] a latching fault output stays set until power cycle or software clear.
// [R15] the monitor five flag reads at bit 0 of register 00h.
// [R16] latched bits set only on a rising edge of their source.
// [R17] writes to read-only bits are ignored; control bits read back as written.
`include "micro_support_params.svh"
module micro_support_control_bits (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire micro_support_pkg::reg_req_t   req,
  output logic [7:0]                         rdata,
  input  wire logic                          power_request_pin,
  input  wire logic                          line_sense_pin,
  input  wire logic                          power_pass_en,
  input  wire logic                          line_pass_en,
  input  wire logic [7:0]                    live_flags,
  input  wire micro_support_pkg::fault_src_t faults,
  input  wire logic                          fault_latching,
  input  wire logic                          ramp_release,
  input  wire logic                          power_cycle,
  output logic                               power_on_int,
  output logic                               line_sense_int,
  output logic                               power_request_debounce_in,
  output logic                               line_sense_pass,
  output logic                               share_clamp_release,
  output logic                               fault_output_pin,
  output logic                               alert
);
  import micro_support_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pwr_sync_reg;
  logic [2:0] line_sync_reg;
  logic       pwr_state_reg;
  logic       line_state_reg;

  // three stages; state moves only when the last two agree
  // one late flop alone can catch a slow pin edge half-way, so it never moves the state
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_sync_reg   <= 3'h0;
      line_sync_reg  <= 3'h0;
      pwr_state_reg  <= 1'b0;
      line_state_reg <= 1'b0;
    end else begin
      pwr_sync_reg  <= {pwr_sync_reg[1:0], power_request_pin};
      line_sync_reg <= {line_sync_reg[1:0], line_sense_pin};
      if (pwr_sync_reg[1] == pwr_sync_reg[2]) begin
        pwr_state_reg <= pwr_sync_reg[2];
      end
      if (line_sync_reg[1] == line_sync_reg[2]) begin
        line_state_reg <= line_sync_reg[2];
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] power_line_reg;
  logic [7:0] clamp_fault_reg;
  logic       wr_power_line;
  logic       wr_clamp_fault;

  assign wr_power_line  = req.wr && (req.addr == `OFS_POWER_LINE);
  assign wr_clamp_fault = req.wr && (req.addr == `OFS_CLAMP_FAULT);

  // [R17] only control offsets store writes
  always_ff @(posedge clk) begin
    if (rst) begin
      power_line_reg  <= `RST_POWER_LINE;
      clamp_fault_reg <= `RST_CLAMP_FAULT;
    end else begin
      if (wr_power_line) begin
        power_line_reg <= req.wdata;
      end
      if (wr_clamp_fault) begin
        clamp_fault_reg <= req.wdata;
      end
    end
  end

  // ****************************************
  // latched fault mirrors
  // ****************************************
  logic [23:0] src_now;
  logic [23:0] src_prev_reg;
  logic [23:0] latch_reg;
  logic [2:0]  rd_latch;

  assign src_now  = {faults.status_one, faults.status_two, faults.status_three};
  assign rd_latch = {req.rd && (req.addr == `OFS_LATCH_ONE),
                     req.rd && (req.addr == `OFS_LATCH_TWO),
                     req.rd && (req.addr == `OFS_LATCH_THREE)};

  // previous source levels for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      src_prev_reg <= 24'h000000;
    end else begin
      src_prev_reg <= src_now;
    end
  end

  // per bit: rising edge sets, read clears only once the fault is gone
  // an edge in the cycle of a read wins: losing a fault costs more than one extra read
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi++) begin : g_latch
      always_ff @(posedge clk) begin
        if (rst) begin
          latch_reg[gi] <= 1'b0;
        // [R16] set on rising edge only
        end else if (src_now[gi] && !src_prev_reg[gi]) begin
          latch_reg[gi] <= 1'b1;
        // [R1] read-clear unless fault persists
        end else if (rd_latch[gi/8] && !src_now[gi]) begin
          latch_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // fault output latch and alert
  // ****************************************
  logic fault_latch_reg;
  logic any_fault_edge;

  assign any_fault_edge = |(src_now & ~src_prev_reg);

  // [R14] latching mode holds until power cycle or software clear; a new edge wins
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_latch_reg <= 1'b0;
    end else if (any_fault_edge) begin
      fault_latch_reg <= 1'b1;
    // [R13] software clear of the latch
    end else if (power_cycle || (wr_clamp_fault && req.wdata[`BIT_FAULT_CLEAR])) begin
      fault_latch_reg <= 1'b0;
    end else if (!fault_latching && !(|src_now)) begin
      fault_latch_reg <= 1'b0;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      power_on_int              <= 1'b0;
      line_sense_int            <= 1'b0;
      power_request_debounce_in <= 1'b0;
      line_sense_pass           <= 1'b0;
      share_clamp_release       <= 1'b0;
      fault_output_pin          <= 1'b0;
      alert                     <= 1'b0;
    end else begin
      // [R4] soft power-on bit drives power-on
      power_on_int <= power_line_reg[`BIT_SOFT_PWR];
      // [R9] soft line-sense bit drives line function
      line_sense_int <= power_line_reg[`BIT_SOFT_LINE];
      // [R5] pin reaches debounce only when passed
      power_request_debounce_in <= power_pass_en & pwr_state_reg;
      // [R10] line pass-through gated, mirror unaffected
      line_sense_pass <= line_pass_en & line_state_reg;
      // [R11] software release overrides ramp release
      share_clamp_release <= ramp_release | clamp_fault_reg[`BIT_CLAMP_REL];
      // [R12] software drive of fault pin
      fault_output_pin <= fault_latch_reg | clamp_fault_reg[`BIT_FAULT_DRIVE];
      // [R7] any fault raises alert
      alert <= fault_latch_reg;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] rdata_next;

  // unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    case (req.addr)
      // [R15] live flags incl monitor five
      `OFS_LIVE_FLAGS:   rdata_next = live_flags;
      // [R3] request mirror at bit 6
      `OFS_INPUT_MIRROR: begin
        rdata_next[`BIT_PWR_MIRROR]  = pwr_state_reg;
        // [R8] line mirror at bit 7
        rdata_next[`BIT_LINE_MIRROR] = line_state_reg;
      end
      `OFS_POWER_LINE:   rdata_next = power_line_reg;
      `OFS_CLAMP_FAULT:  rdata_next = clamp_fault_reg;
      `OFS_LATCH_ONE:    rdata_next = latch_reg[23:16];
      `OFS_LATCH_TWO:    rdata_next = latch_reg[15:8];
      `OFS_LATCH_THREE:  rdata_next = latch_reg[7:0];
      default:           rdata_next = 8'h00;
    endcase
  end

  // read data lands one cycle after the strobe and holds
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rdata_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // latched mirrors, soft control outputs, the request pass gate and the fault output latch
  a_read_clear: assert property (@(posedge clk) disable iff (rst) // [R1]
    (req.rd && req.addr == `OFS_LATCH_ONE && !src_now[16]) |=> !latch_reg[16])
    else $error("latched bit not cleared by read");
  a_edge_set: assert property (@(posedge clk) disable iff (rst) // [R16]
    $rose(src_now[0]) |=> latch_reg[0])
    else $error("latch missed rising edge");
  a_hold_fault: assert property (@(posedge clk) disable iff (rst) // [R1]
    (latch_reg[8] && src_now[8]) |=> latch_reg[8])
    else $error("latch dropped while fault present");
  a_power_ctrl: assert property (@(posedge clk) disable iff (rst) // [R4]
    (wr_power_line) |=> ##1 (power_on_int == $past(req.wdata[`BIT_SOFT_PWR], 2)))
    else $error("power-on not following control bit");
  a_line_ctrl: assert property (@(posedge clk) disable iff (rst) // [R9]
    (wr_power_line) |=> ##1 (line_sense_int == $past(req.wdata[`BIT_SOFT_LINE], 2)))
    else $error("line sense not following control bit");
  a_pass_gate: assert property (@(posedge clk) disable iff (rst) // [R5]
    !power_pass_en |=> !power_request_debounce_in)
    else $error("request passed while pass disabled");
  a_clamp_rel: assert property (@(posedge clk) disable iff (rst) // [R11]
    clamp_fault_reg[`BIT_CLAMP_REL] |=> share_clamp_release)
    else $error("clamp not released by software");
  a_fault_drive: assert property (@(posedge clk) disable iff (rst) // [R12]
    clamp_fault_reg[`BIT_FAULT_DRIVE] |=> fault_output_pin)
    else $error("fault pin not driven by software");
  a_soft_clear: assert property (@(posedge clk) disable iff (rst) // [R13]
    (wr_clamp_fault && req.wdata[`BIT_FAULT_CLEAR] && !any_fault_edge) |=> ##1 !alert)
    else $error("software clear did not drop alert");
  a_alert_fault: assert property (@(posedge clk) disable iff (rst) // [R7]
    any_fault_edge |=> ##1 alert)
    else $error("fault did not raise alert");
  a_read_two: assert property (@(posedge clk) disable iff (rst) // [R1]
    (req.rd && req.addr == `OFS_LATCH_TWO && !src_now[8]) |=> !latch_reg[8])
    else $error("second mirror bit not cleared by read");

  // pin mirrors, pass-through gates and the live flags
  a_request_mirror: assert property (@(posedge clk) disable iff (rst) // [R3]
    (req.rd && req.addr == `OFS_INPUT_MIRROR) |=> (rdata[`BIT_PWR_MIRROR] == $past(pwr_state_reg)))
    else $error("request mirror read wrong");
  a_line_mirror: assert property (@(posedge clk) disable iff (rst) // [R8]
    (req.rd && req.addr == `OFS_INPUT_MIRROR) |=> (rdata[`BIT_LINE_MIRROR] == $past(line_state_reg)))
    else $error("line mirror read wrong");
  a_request_pass: assert property (@(posedge clk) disable iff (rst) // [R5]
    (power_pass_en && pwr_state_reg) |=> power_request_debounce_in)
    else $error("request not passed while pass enabled");
  a_line_gate: assert property (@(posedge clk) disable iff (rst) // [R10]
    !line_pass_en |=> !line_sense_pass)
    else $error("line sense passed while pass disabled");
  a_line_pass: assert property (@(posedge clk) disable iff (rst) // [R10]
    (line_pass_en && line_state_reg) |=> line_sense_pass)
    else $error("line sense not passed while pass enabled");
  a_monitor_five: assert property (@(posedge clk) disable iff (rst) // [R15]
    (req.rd && req.addr == `OFS_LIVE_FLAGS) |=> (rdata[`BIT_MONITOR_FIVE] == $past(live_flags[`BIT_MONITOR_FIVE])))
    else $error("monitor five flag read wrong");

  // stored control bits and the latching fault output
  a_ctrl_hold: assert property (@(posedge clk) disable iff (rst) // [R17]
    (!wr_power_line && !wr_clamp_fault) |=> ($stable(power_line_reg) && $stable(clamp_fault_reg)))
    else $error("control register changed without a write");
  a_latch_hold: assert property (@(posedge clk) disable iff (rst) // [R14]
    (fault_latching && fault_latch_reg && !power_cycle && !(wr_clamp_fault && req.wdata[`BIT_FAULT_CLEAR]))
    |=> fault_latch_reg)
    else $error("latching fault output dropped without a clear");
  a_alert_pin: assert property (@(posedge clk) disable iff (rst) // [R7]
    alert |-> fault_output_pin)
    else $error("alert raised without the fault pin");

  // main scenarios reached at least once
  c_read_clear: cover property (@(posedge clk) disable iff (rst) $fell(latch_reg[0]));
  c_alert: cover property (@(posedge clk) disable iff (rst) $rose(alert));
  c_power_off: cover property (@(posedge clk) disable iff (rst) $fell(power_on_int));
  c_mirror_change: cover property (@(posedge clk) disable iff (rst) $changed(pwr_state_reg));
  c_drop_unlatched: cover property (@(posedge clk) disable iff (rst) !fault_latching && $fell(fault_latch_reg));
endmodule : micro_support_control_bits

// ### core/micro_support_params.svh
// constants for the processor-support register bank
// assumes inclusion by the bank module only
`ifndef MICRO_SUPPORT_PARAMS_SVH
`define MICRO_SUPPORT_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_LIVE_FLAGS    8'h00
`define OFS_INPUT_MIRROR  8'h02
`define OFS_POWER_LINE    8'h12
`define OFS_CLAMP_FAULT   8'h13
`define OFS_LATCH_ONE     8'h2A
`define OFS_LATCH_TWO     8'h2B
`define OFS_LATCH_THREE   8'h2C
// ****************************************
// field positions
// ****************************************
`define BIT_MONITOR_FIVE  0
`define BIT_PWR_MIRROR    6
`define BIT_LINE_MIRROR   7
`define BIT_SOFT_PWR      1
`define BIT_SOFT_LINE     5
`define BIT_CLAMP_REL     2
`define BIT_FAULT_DRIVE   1
`define BIT_FAULT_CLEAR   0
// ****************************************
// reset values
// ****************************************
`define RST_POWER_LINE    8'h00
`define RST_CLAMP_FAULT   8'h00
`define RST_LATCH         8'h00
`endif

// ### core/micro_support_pkg.sv
// types shared by the processor-support register bank
// assumes the params header sits beside it
package micro_support_pkg;
  // one register access from the serial bus engine
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // fault sources feeding the three latched mirrors
  typedef struct packed {
    logic [7:0] status_one;
    logic [7:0] status_two;
    logic [7:0] status_three;
  } fault_src_t;
endpackage : micro_support_pkg

// ### dv/mcu_model.sv
// microcontroller model driving the register request port of the bank
// assumes the bank takes req on rising clk; this model changes req at falling clk
module mcu_model (
  input  wire logic                        clk,
  output micro_support_pkg::reg_req_t      req,
  input  wire logic [7:0]                  rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import micro_support_pkg::*;
  // ****************************************
  // register access tasks
  // ****************************************
  // idle bus from time zero so no stray strobe is taken
  initial req = '0;
  // one-cycle write strobe, dropped a full cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask : wr
  // read data is registered, so it is settled by the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
    d = rdata;
  endtask : rd
  task automatic rd_clear(input logic [7:0] a, output int n);
    logic [7:0] d;
    n = 0;
    d = 8'hFF;
    // bounded, a stuck latch must not hang the run
    while (d !== 8'h00 && n < 8) begin
      rd(a, d);
      n++;
    end
  endtask : rd_clear
  task automatic follow(input logic [7:0] keep);
    logic [7:0] m;
    rd(8'h02, m);
    wr(8'h12, keep | {6'h00, m[6], 1'b0});
  endtask : follow
endmodule : mcu_model

// ### dv/tb_top.sv
// self-checking bench for the processor-support register bank
// assumes a single clk domain; the microcontroller model issues all register traffic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import micro_support_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  reg_req_t   req;
  logic [7:0] rdata, live_flags, outs, d;
  fault_src_t faults;
  logic       power_request_pin, line_sense_pin, power_pass_en, line_pass_en;
  logic       fault_latching, ramp_release, power_cycle;
  logic       power_on_int, line_sense_int, power_request_debounce_in;
  logic       line_sense_pass, share_clamp_release, fault_output_pin, alert;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         n;
  logic [7:0] regs [5] = '{8'h12, 8'h13, 8'h2A, 8'h2B, 8'h2C};
  // all outputs but rdata packed into one byte so one compare covers them
  assign outs = {1'b0, power_on_int, line_sense_int, power_request_debounce_in,
                 line_sense_pass, share_clamp_release, fault_output_pin, alert};
  always #2.5 clk = ~clk;
  micro_support_control_bits micro_support_control_bits_i (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .power_request_pin(power_request_pin),
    .line_sense_pin(line_sense_pin), .power_pass_en(power_pass_en), .line_pass_en(line_pass_en),
    .live_flags(live_flags), .faults(faults), .fault_latching(fault_latching),
    .ramp_release(ramp_release), .power_cycle(power_cycle), .power_on_int(power_on_int),
    .line_sense_int(line_sense_int), .power_request_debounce_in(power_request_debounce_in),
    .line_sense_pass(line_sense_pass), .share_clamp_release(share_clamp_release),
    .fault_output_pin(fault_output_pin), .alert(alert));
  mcu_model mcu_model_i (.clk(clk), .req(req), .rdata(rdata));
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check
  task automatic test_done;
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic wait_n(input int c);
    repeat (c) @(negedge clk);
  endtask : wait_n
  // watchdog: the tests need about 140 cycles
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {power_request_pin, line_sense_pin, power_pass_en, line_pass_en} = 4'h0;
    {fault_latching, ramp_release, power_cycle} = 3'h0;
    live_flags = 8'h00;
    faults = '0;
    wait_n(5);
    rst = 1'b0;
    check(8'h00, outs);
    foreach (regs[i]) begin
      mcu_model_i.rd(regs[i], d);
      check(8'h00, d);
    end
    // pin mirrors and pass-through, with sync delay allowed for
    {power_request_pin, power_pass_en, line_pass_en} = 3'h7;
    wait_n(6);
    mcu_model_i.rd(8'h02, d);
    check(8'h40, d);
    check(8'h10, outs);
    // request pin stays high with its pass-through off: mirrored but not passed
    {power_request_pin, line_sense_pin, power_pass_en} = 3'h6;
    wait_n(6);
    mcu_model_i.rd(8'h02, d);
    check(8'hC0, d);
    check(8'h08, outs);
    line_pass_en = 1'b0;
    wait_n(4);
    check(8'h00, outs);
    mcu_model_i.wr(8'h02, 8'hFF);
    mcu_model_i.rd(8'h02, d);
    check(8'hC0, d);
    mcu_model_i.wr(8'h55, 8'hFF);
    mcu_model_i.rd(8'h55, d);
    check(8'h00, d);
    // soft power-on and line-sense bits
    mcu_model_i.wr(8'h12, 8'h22);
    mcu_model_i.rd(8'h12, d);
    check(8'h22, d);
    check(8'h60, outs);
    mcu_model_i.wr(8'h12, 8'h20);
    wait_n(2);
    check(8'h20, outs);
    mcu_model_i.follow(8'h20);
    wait_n(2);
    check(8'h60, outs);
    power_request_pin = 1'b0;
    wait_n(6);
    mcu_model_i.follow(8'h20);
    wait_n(2);
    check(8'h20, outs);
    mcu_model_i.wr(8'h12, 8'h00);
    live_flags = 8'hA5;
    mcu_model_i.rd(8'h00, d);
    check(8'hA5, d);
    // share clamp: soft release and ramp release, then the soft fault pin drive
    mcu_model_i.wr(8'h13, 8'h04);
    wait_n(2);
    check(8'h04, outs);
    mcu_model_i.wr(8'h13, 8'h00);
    wait_n(2);
    check(8'h00, outs);
    ramp_release = 1'b1;
    wait_n(2);
    check(8'h04, outs);
    ramp_release = 1'b0;
    mcu_model_i.wr(8'h13, 8'h02);
    mcu_model_i.rd(8'h13, d);
    check(8'h02, d);
    check(8'h02, outs);
    mcu_model_i.wr(8'h13, 8'h00);
    // latched fault: read while present, then after it has gone
    fault_latching = 1'b1;
    faults.status_one = 8'h01;
    wait_n(3);
    check(8'h03, outs);
    mcu_model_i.rd(8'h2A, d);
    check(8'h01, d);
    mcu_model_i.rd(8'h2A, d);
    check(8'h01, d);
    faults.status_one = 8'h00;
    mcu_model_i.rd_clear(8'h2A, n);
    check(8'h02, n[7:0]);
    check(8'h03, outs);
    mcu_model_i.wr(8'h13, 8'h01);
    wait_n(2);
    check(8'h00, outs);
    // a held source must not re-set the latch after a soft clear
    faults.status_three = 8'h80;
    wait_n(3);
    check(8'h03, outs);
    mcu_model_i.wr(8'h13, 8'h01);
    wait_n(2);
    check(8'h00, outs);
    faults.status_three = 8'h40;
    wait_n(3);
    check(8'h03, outs);
    power_cycle = 1'b1;
    wait_n(1);
    power_cycle = 1'b0;
    wait_n(2);
    check(8'h00, outs);
    // third mirror: the gone bit clears, the held bit stays
    mcu_model_i.rd(8'h2C, d);
    check(8'hC0, d);
    mcu_model_i.rd(8'h2C, d);
    check(8'h40, d);
    // non-latching fault output follows its sources
    fault_latching = 1'b0;
    faults.status_two = 8'h01;
    faults.status_three = 8'h01;
    wait_n(3);
    check(8'h03, outs);
    mcu_model_i.rd(8'h2B, d);
    check(8'h01, d);
    faults = '0;
    wait_n(2);
    check(8'h00, outs);
    mcu_model_i.rd(8'h2B, d);
    check(8'h01, d);
    mcu_model_i.rd(8'h2B, d);
    check(8'h00, d);
    mcu_model_i.rd_clear(8'h2C, n);
    check(8'h02, n[7:0]);
    test_done();
  end
endmodule : tb_top
